// >>> core/transfer_controller.sv
`timescale 1ns/100ps
`include "dma_regs.svh"
// How it works
// RULE1: Channel 0 source holds 20-bit address.
// RULE2: Channel 0 destination holds 20-bit address.
// RULE3: I/O address bits 17:16 pick request.
// RULE4: Channel 0 count decrements per byte.
// RULE5: Software loads count before enabling.
// RULE6: Byte counts have no reset value.
// RULE7: Channel 1 memory address holds 20 bits.
// RULE8: Channel 1 I/O address, upper byte.
// RULE9: Channel 1 I/O upper byte resets zero.
// RULE10: Channel 1 runs when enable and main.
// RULE11: Channel 1 enable clears at terminal count.
// RULE12: Channel 1 idle plus irq enable interrupts.
// RULE13: Channel 0 runs when enable and main.
// RULE14: Channel 0 enable clears at terminal count.
// RULE15: Channel 0 idle plus irq enable interrupts.
// RULE16: Software clears guard 1 to change enable.
// RULE17: Software clears guard 0 to change enable.
// RULE18: Guarded channel 1 write sets main enable.
// RULE19: Guarded channel 0 write sets main enable.
// RULE20: Guard bits always read as one.
// RULE21: Channel enables reset to zero.
// RULE22: Channel 1 irq enable gates, resets zero.
// RULE23: NMI clears main enable; reset clears.
// RULE24: Channel 0 irq enable gates, resets zero.
// RULE25: Unguarded write leaves enable unchanged.
module transfer_controller #(
    parameter int FIFO_DEPTH = `FIFO_WORDS
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic nmi,
    input wire logic ch0_src_io,
    input wire logic ch0_dst_io,
    input wire logic ch1_io_to_mem,
    input wire dma_pkg::req_in_t reqs,
    input wire logic ext_request_pin1,
    output logic bus_req,
    output dma_pkg::bus_cmd_t bus_cmd,
    input wire logic bus_ack,
    input wire logic [7:0] bus_rdata,
    output logic dma_irq
);
    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("transfer_controller: FIFO_DEPTH too small");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Programmable state
    logic [19:0] src_addr_c0;
    logic [19:0] dst_addr_c0;
    logic [19:0] mem_addr_c1;
    logic [15:0] io_addr_c1;
    logic [7:0] io_addr_c1_upper;
    logic [15:0] count_c0;
    logic [15:0] count_c1;
    logic chan1_enable;
    logic chan0_enable;
    logic chan1_irq_enable;
    logic chan0_irq_enable;
    logic main_xfer_enable;
    logic [7:0] xfer_status;

    // Engine state
    dma_pkg::eng_state_t state;
    logic sel;
    logic [16:0] rd_left;
    logic go0;
    logic go1;
    logic run;
    logic req0;
    logic src_ok;
    logic dst_ok;
    logic [19:0] rd_addr;
    logic rd_io;
    logic [19:0] wr_addr;
    logic wr_io;
    logic [15:0] cur_count;
    logic rd_done;
    logic wr_done;
    logic last_byte;
    logic can_read;
    logic can_write;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic wr_reg;

    assign wr_reg = io_wr;
    assign go0 = chan0_enable && main_xfer_enable; // RULE13
    assign go1 = chan1_enable && main_xfer_enable; // RULE10
    assign run = sel ? go1 : go0;
    assign rd_done = (state == dma_pkg::ENG_WAIT_RD) && bus_ack;
    assign wr_done = (state == dma_pkg::ENG_WAIT_WR) && bus_ack;
    assign cur_count = sel ? count_c1 : count_c0;
    assign last_byte = wr_done && (cur_count == 16'h0001);

    ////////////////////////////////////////////////////////////////////////
    // Address paths of the channel being served
    always_comb begin
        if (sel) begin
            rd_addr = ch1_io_to_mem ? {4'h0, io_addr_c1} : mem_addr_c1;
            rd_io = ch1_io_to_mem;
            wr_addr = ch1_io_to_mem ? mem_addr_c1 : {4'h0, io_addr_c1};
            wr_io = !ch1_io_to_mem;
        end else begin
            rd_addr = src_addr_c0;
            rd_io = ch0_src_io;
            wr_addr = dst_addr_c0;
            wr_io = ch0_dst_io;
        end
    end

    // Channel 0 request comes from whichever side is I/O
    request_select u_req_sel (
        .sel(ch0_src_io ? src_addr_c0[`REQ_SEL_HI:`REQ_SEL_LO]
                        : dst_addr_c0[`REQ_SEL_HI:`REQ_SEL_LO]), // RULE3
        .reqs(reqs),
        .req(req0)
    );

    // Memory sides never wait; I/O sides wait for their request
    always_comb begin
        if (sel) begin
            src_ok = !rd_io || ext_request_pin1;
            dst_ok = !wr_io || ext_request_pin1;
        end else begin
            src_ok = !rd_io || req0;
            dst_ok = !wr_io || req0;
        end
    end

    assign can_read = run && (rd_left != 17'h00000) && fifo_in_ready && src_ok;
    assign can_write = fifo_out_valid && dst_ok;

    ////////////////////////////////////////////////////////////////////////
    // Read bytes park here until the destination takes them
    byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_valid(rd_done),
        .in_ready(fifo_in_ready),
        .in_data(bus_rdata),
        .out_valid(fifo_out_valid),
        .out_ready(wr_done),
        .out_data(fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Engine: reads run ahead while the FIFO has room, writes drain it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= dma_pkg::ENG_IDLE;
            sel <= 1'b0;
            rd_left <= 17'h00000;
            bus_req <= 1'b0;
            bus_cmd <= '0;
        end else begin
            case (state)
                dma_pkg::ENG_IDLE: begin
                    // Channel 0 has priority over channel 1
                    if (go0) begin
                        sel <= 1'b0;
                        rd_left <= {count_c0 == 16'h0000, count_c0};
                        state <= dma_pkg::ENG_ISSUE;
                    end else if (go1) begin
                        sel <= 1'b1;
                        rd_left <= {count_c1 == 16'h0000, count_c1};
                        state <= dma_pkg::ENG_ISSUE;
                    end
                end
                dma_pkg::ENG_ISSUE: begin
                    if (can_read) begin
                        bus_req <= 1'b1;
                        bus_cmd <= '{addr: rd_addr, is_io: rd_io, we: 1'b0,
                                     wdata: 8'h00};
                        state <= dma_pkg::ENG_WAIT_RD;
                    end else if (can_write) begin
                        bus_req <= 1'b1;
                        bus_cmd <= '{addr: wr_addr, is_io: wr_io, we: 1'b1,
                                     wdata: fifo_out_data};
                        state <= dma_pkg::ENG_WAIT_WR;
                    end else if (!fifo_out_valid &&
                                 (!run || rd_left == 17'h00000)) begin
                        // Halted or finished with nothing buffered
                        state <= dma_pkg::ENG_IDLE;
                    end
                end
                dma_pkg::ENG_WAIT_RD: begin
                    if (bus_ack) begin
                        bus_req <= 1'b0;
                        rd_left <= rd_left - 17'h00001;
                        state <= dma_pkg::ENG_ISSUE;
                    end
                end
                dma_pkg::ENG_WAIT_WR: begin
                    if (bus_ack) begin
                        bus_req <= 1'b0;
                        state <= dma_pkg::ENG_ISSUE;
                    end
                end
                default: begin
                    state <= dma_pkg::ENG_IDLE;
                    bus_req <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address registers; software writes win over the engine's stepping
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            src_addr_c0 <= `RST_ADDR;
            dst_addr_c0 <= `RST_ADDR;
            mem_addr_c1 <= `RST_ADDR;
            io_addr_c1 <= {`RST_BYTE, `RST_BYTE};
            io_addr_c1_upper <= `RST_BYTE; // RULE9
        end else begin
            // Memory addresses step by one, I/O addresses stay put
            if (rd_done && !rd_io) begin
                if (sel) begin
                    mem_addr_c1 <= mem_addr_c1 + 20'h00001;
                end else begin
                    src_addr_c0 <= src_addr_c0 + 20'h00001;
                end
            end
            if (wr_done && !wr_io) begin
                if (sel) begin
                    mem_addr_c1 <= mem_addr_c1 + 20'h00001;
                end else begin
                    dst_addr_c0 <= dst_addr_c0 + 20'h00001;
                end
            end
            if (wr_reg) begin
                case (io_addr)
                    `REG_SRC_C0_L: src_addr_c0[7:0] <= io_wdata; // RULE1
                    `REG_SRC_C0_H: src_addr_c0[15:8] <= io_wdata; // RULE1
                    `REG_SRC_C0_B: src_addr_c0[19:16] <= io_wdata[3:0]; // RULE1
                    `REG_DST_C0_L: dst_addr_c0[7:0] <= io_wdata; // RULE2
                    `REG_DST_C0_H: dst_addr_c0[15:8] <= io_wdata; // RULE2
                    `REG_DST_C0_B: dst_addr_c0[19:16] <= io_wdata[3:0]; // RULE2
                    `REG_MEM_C1_L: mem_addr_c1[7:0] <= io_wdata; // RULE7
                    `REG_MEM_C1_H: mem_addr_c1[15:8] <= io_wdata; // RULE7
                    `REG_MEM_C1_B: mem_addr_c1[19:16] <= io_wdata[3:0]; // RULE7
                    `REG_IO_C1_L: io_addr_c1[7:0] <= io_wdata; // RULE8
                    `REG_IO_C1_H: io_addr_c1[15:8] <= io_wdata; // RULE8
                    `REG_IO_C1_UPPER: io_addr_c1_upper <= io_wdata; // RULE8
                    default: begin
                    end
                endcase
            end
        end
    end

    // Counts: no reset, software must load them before enabling
    always_ff @(posedge ref_clk) begin // RULE6
        if (wr_done) begin
            if (sel) begin
                count_c1 <= count_c1 - 16'h0001;
            end else begin
                count_c0 <= count_c0 - 16'h0001; // RULE4
            end
        end
        if (wr_reg) begin
            case (io_addr)
                `REG_COUNT_C0_L: count_c0[7:0] <= io_wdata; // RULE5
                `REG_COUNT_C0_H: count_c0[15:8] <= io_wdata; // RULE5
                `REG_COUNT_C1_L: count_c1[7:0] <= io_wdata;
                `REG_COUNT_C1_H: count_c1[15:8] <= io_wdata;
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enables; termination first, then software, NMI last so it halts
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            chan1_enable <= 1'b0; // RULE21
            chan0_enable <= 1'b0; // RULE21
            chan1_irq_enable <= 1'b0; // RULE22
            chan0_irq_enable <= 1'b0; // RULE24
            main_xfer_enable <= 1'b0; // RULE23
        end else begin
            if (last_byte && sel) begin
                chan1_enable <= 1'b0; // RULE11
            end
            if (last_byte && !sel) begin
                chan0_enable <= 1'b0; // RULE14
            end
            if (wr_reg && io_addr == `REG_XFER_STATUS) begin
                chan1_irq_enable <= io_wdata[`ST_CHAN1_IRQ_EN]; // RULE22
                chan0_irq_enable <= io_wdata[`ST_CHAN0_IRQ_EN]; // RULE24
                // A guard written as 1 protects the enable
                if (!io_wdata[`ST_CHAN1_GUARD]) begin // RULE25 RULE16
                    chan1_enable <= io_wdata[`ST_CHAN1_ENABLE]; // RULE18
                    if (io_wdata[`ST_CHAN1_ENABLE]) begin
                        main_xfer_enable <= 1'b1; // RULE18
                    end
                end
                if (!io_wdata[`ST_CHAN0_GUARD]) begin // RULE25 RULE17
                    chan0_enable <= io_wdata[`ST_CHAN0_ENABLE]; // RULE19
                    if (io_wdata[`ST_CHAN0_ENABLE]) begin
                        main_xfer_enable <= 1'b1; // RULE19
                    end
                end
            end
            if (nmi) begin
                main_xfer_enable <= 1'b0; // RULE23
            end
        end
    end

    // Status byte image; guards read high, reserved bit reads low
    always_comb begin
        xfer_status = 8'h00;
        xfer_status[`ST_CHAN1_ENABLE] = chan1_enable;
        xfer_status[`ST_CHAN0_ENABLE] = chan0_enable;
        xfer_status[`ST_CHAN1_GUARD] = 1'b1; // RULE20
        xfer_status[`ST_CHAN0_GUARD] = 1'b1; // RULE20
        xfer_status[`ST_CHAN1_IRQ_EN] = chan1_irq_enable;
        xfer_status[`ST_CHAN0_IRQ_EN] = chan0_irq_enable;
        xfer_status[`ST_MAIN_ENABLE] = main_xfer_enable;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data registered one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            case (io_addr)
                `REG_SRC_C0_L: io_rdata <= src_addr_c0[7:0];
                `REG_SRC_C0_H: io_rdata <= src_addr_c0[15:8];
                `REG_SRC_C0_B: io_rdata <= {4'h0, src_addr_c0[19:16]};
                `REG_DST_C0_L: io_rdata <= dst_addr_c0[7:0];
                `REG_DST_C0_H: io_rdata <= dst_addr_c0[15:8];
                `REG_DST_C0_B: io_rdata <= {4'h0, dst_addr_c0[19:16]};
                `REG_COUNT_C0_L: io_rdata <= count_c0[7:0];
                `REG_COUNT_C0_H: io_rdata <= count_c0[15:8];
                `REG_MEM_C1_L: io_rdata <= mem_addr_c1[7:0];
                `REG_MEM_C1_H: io_rdata <= mem_addr_c1[15:8];
                `REG_MEM_C1_B: io_rdata <= {4'h0, mem_addr_c1[19:16]};
                `REG_IO_C1_L: io_rdata <= io_addr_c1[7:0];
                `REG_IO_C1_H: io_rdata <= io_addr_c1[15:8];
                `REG_IO_C1_UPPER: io_rdata <= io_addr_c1_upper;
                `REG_COUNT_C1_L: io_rdata <= count_c1[7:0];
                `REG_COUNT_C1_H: io_rdata <= count_c1[15:8];
                `REG_XFER_STATUS: io_rdata <= xfer_status;
                default: io_rdata <= 8'h00;
            endcase
        end
    end

    // Interrupt is a level while a channel sits idle with its irq enable set
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dma_irq <= 1'b0;
        end else begin
            dma_irq <= (!chan1_enable && chan1_irq_enable) // RULE12
                    || (!chan0_enable && chan0_irq_enable); // RULE15
        end
    end
endmodule

// >>> common/dma_regs.svh
`ifndef DMA_REGS_SVH
`define DMA_REGS_SVH
// Register byte locations in I/O space
`define REG_SRC_C0_L 8'h20
`define REG_SRC_C0_H 8'h21
`define REG_SRC_C0_B 8'h22
`define REG_DST_C0_L 8'h23
`define REG_DST_C0_H 8'h24
`define REG_DST_C0_B 8'h25
`define REG_COUNT_C0_L 8'h26
`define REG_COUNT_C0_H 8'h27
`define REG_MEM_C1_L 8'h28
`define REG_MEM_C1_H 8'h29
`define REG_MEM_C1_B 8'h2a
`define REG_IO_C1_L 8'h2b
`define REG_IO_C1_H 8'h2c
`define REG_IO_C1_UPPER 8'h2d
`define REG_COUNT_C1_L 8'h2e
`define REG_COUNT_C1_H 8'h2f
`define REG_XFER_STATUS 8'h30
// Status register bit positions
`define ST_CHAN1_ENABLE 7
`define ST_CHAN0_ENABLE 6
`define ST_CHAN1_GUARD 5
`define ST_CHAN0_GUARD 4
`define ST_CHAN1_IRQ_EN 3
`define ST_CHAN0_IRQ_EN 2
`define ST_MAIN_ENABLE 0
// Request select field in an I/O address
`define REQ_SEL_HI 17
`define REQ_SEL_LO 16
`define REQ_SEL_EXT0 2'b00
`define REQ_SEL_SER0 2'b01
`define REQ_SEL_SER1 2'b10
// Reset values and sizes
`define RST_BYTE 8'h00
`define RST_ADDR 20'h00000
`define FIFO_WORDS 16
`endif

// >>> common/dma_pkg.sv
package dma_pkg;
    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_ISSUE = 2'b01,
        ENG_WAIT_RD = 2'b10,
        ENG_WAIT_WR = 2'b11
    } eng_state_t;

    typedef struct packed {
        logic [19:0] addr;
        logic is_io;
        logic we;
        logic [7:0] wdata;
    } bus_cmd_t;

    typedef struct packed {
        logic ext_request_pin0;
        logic serial0_tx_request;
        logic serial1_tx_request;
    } req_in_t;
endpackage

// >>> core/byte_fifo.sv
`timescale 1ns/100ps
// Small synchronous FIFO, write and read in one clock
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("byte_fifo: DEPTH must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] used;
    logic push;
    logic pop;

    // Full and empty come straight from the fill level
    assign in_ready = (used != (AW+1)'(DEPTH));
    assign out_valid = (used != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // Storage has no reset; only pointers and fill level carry state
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            used <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                used <= used + 1'b1;
            end else if (pop && !push) begin
                used <= used - 1'b1;
            end
        end
    end
endmodule

// >>> core/request_select.sv
`timescale 1ns/100ps
`include "dma_regs.svh"
// Picks the handshake request for channel 0 from two address bits
module request_select (
    input wire logic [1:0] sel,
    input wire dma_pkg::req_in_t reqs,
    output logic req
);
    // Code 11 has no source and never requests
    always_comb begin
        case (sel)
            `REQ_SEL_EXT0: req = reqs.ext_request_pin0;
            `REQ_SEL_SER0: req = reqs.serial0_tx_request;
            `REQ_SEL_SER1: req = reqs.serial1_tx_request;
            default: req = 1'b0;
        endcase
    end
endmodule

// >>> verification/dma_props.sv
`timescale 1ns/100ps
// Port-level checks on the register path, the interrupt and the transfer bus
module dma_props (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic nmi,
    input wire logic bus_req,
    input wire dma_pkg::bus_cmd_t bus_cmd,
    input wire logic bus_ack,
    input wire logic dma_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic st_wr;
    logic armed;
    assign st_wr = io_wr && io_addr == 8'h30;
    // Armed by the first guarded enable write; a request before it is stray
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            armed <= 1'b0;
        end else if (st_wr && (io_wdata[7:6] & ~io_wdata[5:4]) != 2'b00) begin
            armed <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_guard_read;
        io_rd && io_addr == 8'h30 |=> io_rdata[5:4] == 2'b11 && !io_rdata[1];
    endproperty
    property p_upper;
        io_rd && (io_addr == 8'h22 || io_addr == 8'h25 || io_addr == 8'h2a)
            |=> io_rdata[7:4] == 4'h0;
    endproperty
    property p_irq_ie0;
        st_wr && !io_wdata[6] && !io_wdata[4] && io_wdata[2] |-> ##2 dma_irq;
    endproperty
    property p_irq_ie1;
        st_wr && io_wdata[7] == 1'b0 && !io_wdata[5] && io_wdata[3] |-> ##2 dma_irq;
    endproperty
    property p_irq_off;
        st_wr && io_wdata[3:2] == 2'b00 |-> ##2 !dma_irq;
    endproperty
    property p_req_hold;
        bus_req && !bus_ack |=> bus_req && $stable(bus_cmd);
    endproperty
    property p_req_drop;
        bus_req && bus_ack |=> !bus_req;
    endproperty
    property p_armed;
        $rose(bus_req) |-> armed;
    endproperty
    property p_nmi;
        nmi ##1 (io_rd && io_addr == 8'h30 && !io_wr) |=> !io_rdata[0];
    endproperty
    a_guard_read: assert property (p_guard_read) else $error("status guards misread");
    a_upper: assert property (p_upper) else $error("upper nibble not zero");
    a_irq_ie0: assert property (p_irq_ie0) else $error("ch0 idle irq missing");
    a_irq_ie1: assert property (p_irq_ie1) else $error("ch1 idle irq missing");
    a_irq_off: assert property (p_irq_off) else $error("irq without enable");
    a_req_hold: assert property (p_req_hold) else $error("bus request moved");
    a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
    a_armed: assert property (p_armed) else $error("request before enable");
    a_nmi: assert property (p_nmi) else $error("main enable survived nmi");
    // Main scenarios
    c_write: cover property (bus_req && bus_ack && bus_cmd.we);
    c_nmi: cover property (nmi);
    c_irq: cover property ($rose(dma_irq));
endmodule

bind transfer_controller dma_props u_props (.ref_clk(ref_clk), .rstn(rstn), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .nmi(nmi),
    .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_ack(bus_ack), .dma_irq(dma_irq));

// >>> verification/bus_partner.sv
`timescale 1ns/100ps
// Memory and I/O side: acks after a random wait of 0 to 3 cycles, logs writes
module bus_partner (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic bus_req,
    input wire dma_pkg::bus_cmd_t bus_cmd,
    output logic bus_ack,
    output logic [7:0] bus_rdata
);
    logic [1:0] gap;
    int acks;
    dma_pkg::bus_cmd_t wlog[$];
    // Idle data is inverted each cycle so a stale byte never looks valid
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            bus_ack <= 1'b0;
            bus_rdata <= 8'h00;
            gap <= 2'h0;
            acks = 0;
        end else if (bus_ack || !bus_req) begin
            bus_ack <= 1'b0;
            bus_rdata <= ~bus_rdata;
        end else if (gap != 2'h0) begin
            gap <= gap - 2'h1;
            bus_rdata <= ~bus_rdata;
        end else begin
            bus_ack <= 1'b1;
            bus_rdata <= bus_cmd.addr[7:0] ^ 8'ha5;
            gap <= 2'($urandom_range(3));
            acks++;
            if (bus_cmd.we) begin
                wlog.push_back(bus_cmd);
            end
        end
    end
endmodule

// >>> verification/two_channel_dma_address_count_enable_tb.sv
`timescale 1ns/100ps
module two_channel_dma_address_count_enable_tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, d, bus_rdata;
    logic io_wr = 0, io_rd = 0, nmi = 0, src_io = 0, pin1 = 0, bus_req, bus_ack, dma_irq;
    dma_pkg::req_in_t reqs = '0;
    dma_pkg::bus_cmd_t bus_cmd;
    int mismatches = 0;
    int checks = 0;
    logic [19:0] src, dst, n;
    always #5 ref_clk = ~ref_clk;
    transfer_controller u_dut (.ref_clk(ref_clk), .rstn(rstn), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .nmi(nmi),
        .ch0_src_io(src_io), .ch0_dst_io(1'b0), .ch1_io_to_mem(1'b0), .reqs(reqs),
        .ext_request_pin1(pin1), .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_ack(bus_ack),
        .bus_rdata(bus_rdata), .dma_irq(dma_irq));
    bus_partner u_bus (.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .bus_cmd(bus_cmd),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata));
    ////////////////////////////////////////////////////////////////////////
    // Byte the partner returns for a read at this address
    function automatic logic [7:0] pat(logic [19:0] a);
        return a[7:0] ^ 8'ha5;
    endfunction
    task automatic tick(int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic cmp(logic [19:0] got, logic [19:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Strobes drop for a cycle so no signal is set twice in one step
    task automatic wr(logic [7:0] a, logic [7:0] v);
        io_addr = a;
        io_wdata = v;
        io_wr = 1'b1;
        tick(1);
        io_wr = 1'b0;
        tick(1);
    endtask
    task automatic wr3(logic [7:0] a, logic [19:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
        wr(a + 8'h02, {4'h0, v[19:16]});
    endtask
    task automatic rd(logic [7:0] a);
        io_addr = a;
        io_rd = 1'b1;
        tick(1);
        io_rd = 1'b0;
        d = io_rdata;
        tick(1);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Polls status until the channel enable drops, bounded
    task automatic wait_idle(int b);
        int k;
        for (k = 0; k < 300; k++) begin
            rd(8'h30);
            if (d[b] === 1'b0 && bus_req === 1'b0) break;
        end
        if (k == 300) begin
            mismatches++;
            conclude();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int i, a, s;
        logic [7:0] m;
        void'($urandom(65));
        tick(3);
        rstn = 1'b1;
        tick(1);
        rd(8'h30);
        cmp(d, 8'h30);
        rd(8'h2d);
        cmp(d, 8'h00);
        rd(8'h3f);
        cmp(d, 8'h00);
        for (a = 8'h20; a <= 8'h2f; a++) begin
            m = 8'($urandom);
            wr(8'(a), m);
            rd(8'(a));
            cmp(d, (a == 8'h22 || a == 8'h25 || a == 8'h2a) ? {4'h0, m[3:0]} : m);
        end
        wr(8'h30, 8'hf0);
        rd(8'h30);
        cmp(d, 8'h30);
        // Memory to memory, single byte first
        for (i = 0; i < 3; i++) begin
            src = 20'($urandom);
            dst = 20'($urandom);
            n = (i == 0) ? 20'd1 : 20'($urandom_range(6, 2));
            u_bus.wlog.delete();
            wr3(8'h20, src);
            wr3(8'h23, dst);
            wr(8'h26, n[7:0]);
            wr(8'h27, n[15:8]);
            wr(8'h30, 8'h44);
            wait_idle(6);
            cmp(20'(u_bus.wlog.size()), n);
            for (s = 0; s < n; s++) begin
                cmp(u_bus.wlog[s].addr, 20'(dst + s));
                cmp(u_bus.wlog[s].wdata, pat(20'(src + s)));
            end
            rd(8'h26);
            cmp(d, 8'h00);
            rd(8'h30);
            cmp(d, 8'h35);
            cmp(dma_irq, 1'b1);
        end
        // I/O source: only the selected request may start the read
        src_io = 1'b1;
        for (i = 0; i < 4; i++) begin
            wr3(8'h20, {2'b00, 2'(i), 16'h0040});
            wr(8'h26, 8'h01);
            wr(8'h27, 8'h00);
            reqs = dma_pkg::req_in_t'(~(3'b100 >> i));
            wr(8'h30, 8'h44);
            s = u_bus.acks;
            tick(20);
            cmp(20'(u_bus.acks), 20'(s));
            reqs = dma_pkg::req_in_t'((i == 3) ? 3'b111 : (3'b100 >> i));
            tick(20);
            rd(8'h30);
            cmp(d[6], i == 3);
            wr(8'h30, 8'h24);
        end
        src_io = 1'b0;
        reqs = '0;
        // Channel 1 stalled by nmi, then restarted
        wr3(8'h28, 20'h01230);
        wr(8'h2b, 8'h77);
        wr(8'h2c, 8'h10);
        wr(8'h2e, 8'h02);
        wr(8'h2f, 8'h00);
        nmi = 1'b1;
        wr(8'h30, 8'h88);
        nmi = 1'b0;
        rd(8'h30);
        cmp(d, 8'hb8);
        pin1 = 1'b1;
        s = u_bus.acks;
        tick(20);
        cmp(20'(u_bus.acks), 20'(s));
        u_bus.wlog.delete();
        wr(8'h30, 8'h88);
        wait_idle(7);
        cmp(20'(u_bus.wlog.size()), 20'd2);
        for (s = 0; s < 2; s++) begin
            cmp(u_bus.wlog[s].addr[15:0], 16'h1077);
            cmp(u_bus.wlog[s].wdata, pat(20'(20'h01230 + s)));
        end
        rd(8'h30);
        cmp(d, 8'h39);
        cmp(dma_irq, 1'b1);
        wr(8'h30, 8'h18);
        tick(2);
        cmp(dma_irq, 1'b1);
        conclude();
    end
endmodule
